// ### common/i2cm_regs.svh
// i2cm_regs.svh: register offsets, field positions, reset values, timing counts
// assumes a 200 MHz system clock and a plain address/strobe register port
`ifndef I2CM_REGS_SVH
`define I2CM_REGS_SVH
`define I2CM_ADDR_RAW 32'h4005_0004
`define I2CM_ADDR_IEN 32'h4005_0008
`define I2CM_ADDR_MSK 32'h4005_0018
`define I2CM_ADDR_CMD 32'h4005_0020
`define I2CM_ADDR_DAT 32'h4005_0080
`define I2CM_B_MPEND 0
`define I2CM_B_ARB 4
`define I2CM_B_SSERR 6
`define I2CM_B_SPEND 8
`define I2CM_B_SNSTR 11
`define I2CM_B_SDESEL 15
`define I2CM_B_MRDY 16
`define I2CM_B_MOV 17
`define I2CM_B_MIDLE 19
`define I2CM_B_EVTO 24
`define I2CM_B_SCLTO 25
`define I2CM_B_CONT 0
`define I2CM_B_START 1
`define I2CM_B_STOP 2
`define I2CM_B_DMA 3
`define I2CM_RAW_RST 32'h0000_0801
`define I2CM_IEN_BITS 32'h030B_8951
`define I2CM_STICKY 32'h030A_8050
`define I2CM_CLK_NS 5
`define I2CM_HALF_NS 1250
`define I2CM_HALF_CYC ((`I2CM_HALF_NS + `I2CM_CLK_NS - 1) / `I2CM_CLK_NS)
`define I2CM_TOUT_NS 20000
`define I2CM_TOUT_CYC (`I2CM_TOUT_NS / `I2CM_CLK_NS)
`endif

// ### common/i2cm_pkg.sv
// i2cm_pkg: state, decode and follow-up enumerations of the master control block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package i2cm_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_BIT = 3'h2,
        ST_PEND = 3'h3,
        ST_STOP = 3'h4
    } i2cm_state_e;
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_RAW = 3'h1,
        SEL_IEN = 3'h2,
        SEL_MSK = 3'h3,
        SEL_CMD = 3'h4,
        SEL_DAT = 3'h5
    } i2cm_sel_e;
    typedef enum logic [1:0] {
        THEN_PEND = 2'h0,
        THEN_STOP = 2'h1,
        THEN_START = 2'h2
    } i2cm_then_e;
endpackage
`default_nettype wire

// ### rtl/i2cm_sync.sv
// i2cm_sync: two-flop synchroniser for the clock and data lines
// assumes idle-high open-drain lines arriving from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module i2cm_sync (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [1:0] async_i,
    output logic [1:0] sync_o
);
    logic [1:0] meta_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= 2'h3;
            sync_o <= 2'h3;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ### rtl/i2cm_ctrl.sv
// i2cm_ctrl: i2c master command register, masked interrupt view and bit engine
// assumes open-drain pins resolved outside and same-clock slave/monitor flags
// Overview of operation
// - masked view shows flags whose enable is set
// - master pending bit0, arb loss 4, error 6
// - slave pending 8, not-stretching 11, deselected 15
// - monitor bits 16,17,19, timeouts 24 and 25
// - command writes other than the dma bit act only in idle or pending, one action each
// - continue bit one advances master, zero ignored
// - start bit one generates a start condition
// - stop bit generates stop, nack first receiving
// - dma enable gates master dma requests
// - dma receive acknowledges bytes automatically
//
// Decided for this implementation: the strobed register port.
`include "i2cm_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module i2cm_ctrl (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic slv_pending_i,
    input wire logic slv_not_stretching_i,
    input wire logic slv_deselected_i,
    input wire logic mon_ready_i,
    input wire logic mon_overflow_i,
    input wire logic mon_idle_i,
    output logic dma_req_o,
    input wire logic dma_ack_i,
    input wire logic [7:0] dma_wdata_i,
    output logic [7:0] dma_rdata_o,
    output logic irq_o
);
    function automatic i2cm_pkg::i2cm_sel_e i2cm_decode(input logic [31:0] a);
        case (a)
            `I2CM_ADDR_RAW: i2cm_decode = i2cm_pkg::SEL_RAW;
            `I2CM_ADDR_IEN: i2cm_decode = i2cm_pkg::SEL_IEN;
            `I2CM_ADDR_MSK: i2cm_decode = i2cm_pkg::SEL_MSK;
            `I2CM_ADDR_CMD: i2cm_decode = i2cm_pkg::SEL_CMD;
            `I2CM_ADDR_DAT: i2cm_decode = i2cm_pkg::SEL_DAT;
            default: i2cm_decode = i2cm_pkg::SEL_NONE;
        endcase
    endfunction

    i2cm_pkg::i2cm_sel_e sel_w;
    i2cm_pkg::i2cm_state_e st_q;
    i2cm_pkg::i2cm_then_e then_q;
    logic [1:0] pins_s;
    logic scl_s, sda_s, scl_d_q, sda_d_q, start_det, stop_det;
    logic ph_q, tick, rcv_q, ack_due_q, rxb_q, last_ack_q;
    logic scl_oe_q, sda_oe_q, arb_ev_q, sserr_ev_q, dma_en_q;
    logic cmd_wr, go_cont, go_start, go_stop, dma_go, mst_pend;
    logic [8:0] cnt_q, tx_sh_q, own_q;
    logic [3:0] nbit_q;
    logic [7:0] rx_sh_q, rx_q, tx_q, tx_now;
    logic [31:0] sticky_q, ien_q, raw_w, set_w, clr_w, rdata_q;
    logic slv_pend_q, slv_nstr_q, mon_rdy_q, busy_q;
    logic [11:0] ev_cnt_q, scl_cnt_q;
    logic ev_run, scl_run, ev_to, scl_to;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    i2cm_sync u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .async_i({scl_i, sda_i}),
        .sync_o(pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];
    assign start_det = scl_s & scl_d_q & sda_d_q & ~sda_s;
    assign stop_det = scl_s & scl_d_q & ~sda_d_q & sda_s;
    assign sel_w = i2cm_decode(addr_i);
    assign tick = (cnt_q == 9'(`I2CM_HALF_CYC - 1));

    // each write is decoded into one-cycle pulses; only the dma bit is stored
    assign cmd_wr = wr_i && (sel_w == i2cm_pkg::SEL_CMD);
    assign go_start = cmd_wr && wdata_i[`I2CM_B_START];
    assign go_stop = cmd_wr && wdata_i[`I2CM_B_STOP];
    assign dma_go = dma_ack_i && dma_req_o;
    assign go_cont = (cmd_wr && wdata_i[`I2CM_B_CONT]) || dma_go;
    assign tx_now = dma_go ? dma_wdata_i : tx_q;
    assign dma_req_o = (st_q == i2cm_pkg::ST_PEND) && dma_en_q;
    assign dma_rdata_o = rx_q;

    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_oe_q;
    assign sda_oe_o = sda_oe_q;
    assign rdata_o = rdata_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dma_en_q <= 1'b0;
        end else if (cmd_wr) begin
            dma_en_q <= wdata_i[`I2CM_B_DMA];
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_q <= 8'h00;
        end else if (dma_go) begin
            tx_q <= dma_wdata_i;
        end else if (wr_i && sel_w == i2cm_pkg::SEL_DAT) begin
            tx_q <= wdata_i[7:0];
        end
    end

    // bit engine: scl held low while pending, released and waited on when high
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= i2cm_pkg::ST_IDLE;
            then_q <= i2cm_pkg::THEN_PEND;
            ph_q <= 1'b0;
            cnt_q <= 9'h000;
            nbit_q <= 4'h0;
            tx_sh_q <= 9'h1FF;
            own_q <= 9'h000;
            rx_sh_q <= 8'h00;
            rx_q <= 8'h00;
            rcv_q <= 1'b0;
            ack_due_q <= 1'b0;
            rxb_q <= 1'b0;
            last_ack_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            arb_ev_q <= 1'b0;
            sserr_ev_q <= 1'b0;
        end else begin
            arb_ev_q <= 1'b0;
            sserr_ev_q <= (go_start || go_stop) && (st_q != i2cm_pkg::ST_PEND)
                && (st_q != i2cm_pkg::ST_IDLE);
            cnt_q <= cnt_q + 9'h001;
            case (st_q)
                i2cm_pkg::ST_IDLE: begin
                    scl_oe_q <= 1'b0;
                    sda_oe_q <= 1'b0;
                    ph_q <= 1'b0;
                    cnt_q <= 9'h000;
                    rcv_q <= 1'b0;
                    ack_due_q <= 1'b0;
                    if (go_start) begin
                        st_q <= i2cm_pkg::ST_START;
                    end else if (go_stop || go_cont) begin
                        sserr_ev_q <= 1'b1;
                    end
                end
                i2cm_pkg::ST_START: begin
                    if (!ph_q) begin
                        sda_oe_q <= 1'b0;
                        if (tick) begin
                            cnt_q <= 9'h000;
                            if (scl_oe_q) begin
                                scl_oe_q <= 1'b0;
                            end else if (scl_s && sda_s) begin
                                sda_oe_q <= 1'b1;
                                ph_q <= 1'b1;
                            end
                        end
                    end else if (tick) begin
                        scl_oe_q <= 1'b1;
                        ph_q <= 1'b0;
                        cnt_q <= 9'h000;
                        st_q <= i2cm_pkg::ST_BIT;
                        tx_sh_q <= {tx_q, 1'b1};
                        own_q <= 9'h1FE;
                        nbit_q <= 4'h9;
                        rcv_q <= tx_q[0];
                        ack_due_q <= 1'b0;
                        rxb_q <= 1'b0;
                        then_q <= i2cm_pkg::THEN_PEND;
                    end
                end
                i2cm_pkg::ST_BIT: begin
                    if (!ph_q) begin
                        sda_oe_q <= ~tx_sh_q[8];
                        if (tick) begin
                            scl_oe_q <= 1'b0;
                            ph_q <= 1'b1;
                            cnt_q <= 9'h000;
                        end
                    end else if (!scl_s) begin
                        // another device stretches the clock
                        cnt_q <= 9'h000;
                    end else if (tick) begin
                        cnt_q <= 9'h000;
                        ph_q <= 1'b0;
                        scl_oe_q <= 1'b1;
                        rx_sh_q <= {rx_sh_q[6:0], sda_s};
                        tx_sh_q <= {tx_sh_q[7:0], 1'b1};
                        own_q <= {own_q[7:0], 1'b0};
                        nbit_q <= nbit_q - 4'h1;
                        if (own_q[8] && tx_sh_q[8] && !sda_s) begin
                            arb_ev_q <= 1'b1;
                            scl_oe_q <= 1'b0;
                            sda_oe_q <= 1'b0;
                            st_q <= i2cm_pkg::ST_IDLE;
                        end else if (nbit_q == 4'h1) begin
                            last_ack_q <= sda_s;
                            if (rxb_q) begin
                                rx_q <= {rx_sh_q[6:0], sda_s};
                                ack_due_q <= 1'b1;
                            end
                            case (then_q)
                                i2cm_pkg::THEN_STOP: st_q <= i2cm_pkg::ST_STOP;
                                i2cm_pkg::THEN_START: st_q <= i2cm_pkg::ST_START;
                                default: st_q <= i2cm_pkg::ST_PEND;
                            endcase
                        end
                    end
                end
                i2cm_pkg::ST_PEND: begin
                    cnt_q <= 9'h000;
                    ph_q <= 1'b0;
                    sda_oe_q <= 1'b0;
                    // continue and stop are only taken here, while the master waits; start also in idle
                    if (go_stop || go_start) begin
                        then_q <= go_stop ? i2cm_pkg::THEN_STOP : i2cm_pkg::THEN_START;
                        if (rcv_q && ack_due_q) begin
                            // receiver refuses the next byte before letting go
                            st_q <= i2cm_pkg::ST_BIT;
                            tx_sh_q <= 9'h1FF;
                            own_q <= 9'h100;
                            nbit_q <= 4'h1;
                            rxb_q <= 1'b0;
                            ack_due_q <= 1'b0;
                        end else begin
                            st_q <= go_stop ? i2cm_pkg::ST_STOP : i2cm_pkg::ST_START;
                        end
                    end else if (go_cont) begin
                        st_q <= i2cm_pkg::ST_BIT;
                        then_q <= i2cm_pkg::THEN_PEND;
                        ack_due_q <= 1'b0;
                        if (rcv_q) begin
                            // the owed acknowledge leads the next byte
                            rxb_q <= 1'b1;
                            nbit_q <= ack_due_q ? 4'h9 : 4'h8;
                            tx_sh_q <= ack_due_q ? 9'h0FF : 9'h1FF;
                            own_q <= ack_due_q ? 9'h100 : 9'h000;
                        end else begin
                            rxb_q <= 1'b0;
                            tx_sh_q <= {tx_now, 1'b1};
                            own_q <= 9'h1FE;
                            nbit_q <= 4'h9;
                        end
                    end
                end
                i2cm_pkg::ST_STOP: begin
                    if (!ph_q) begin
                        sda_oe_q <= 1'b1;
                        if (tick) begin
                            scl_oe_q <= 1'b0;
                            ph_q <= 1'b1;
                            cnt_q <= 9'h000;
                        end
                    end else if (!scl_s) begin
                        cnt_q <= 9'h000;
                    end else if (tick) begin
                        sda_oe_q <= 1'b0;
                        st_q <= i2cm_pkg::ST_IDLE;
                    end
                end
                default: st_q <= i2cm_pkg::ST_IDLE;
            endcase
        end
    end

    // bus activity and time-out counters
    assign ev_run = busy_q && (scl_s == scl_d_q) && !start_det && !stop_det;
    assign scl_run = !scl_s;
    assign ev_to = ev_run && (ev_cnt_q == 12'(`I2CM_TOUT_CYC - 1));
    assign scl_to = scl_run && (scl_cnt_q == 12'(`I2CM_TOUT_CYC - 1));

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
            busy_q <= 1'b0;
            ev_cnt_q <= 12'h000;
            scl_cnt_q <= 12'h000;
        end else begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
            if (start_det) begin
                busy_q <= 1'b1;
            end else if (stop_det) begin
                busy_q <= 1'b0;
            end
            if (!ev_run) begin
                ev_cnt_q <= 12'h000;
            end else if (ev_cnt_q != 12'(`I2CM_TOUT_CYC)) begin
                ev_cnt_q <= ev_cnt_q + 12'h001;
            end
            if (!scl_run) begin
                scl_cnt_q <= 12'h000;
            end else if (scl_cnt_q != 12'(`I2CM_TOUT_CYC)) begin
                scl_cnt_q <= scl_cnt_q + 12'h001;
            end
        end
    end

    // status: levels follow their sources, events stick until written one
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            slv_pend_q <= 1'b0;
            slv_nstr_q <= 1'b1;
            mon_rdy_q <= 1'b0;
        end else begin
            slv_pend_q <= slv_pending_i;
            slv_nstr_q <= slv_not_stretching_i;
            mon_rdy_q <= mon_ready_i;
        end
    end

    // a dma-driven pending state does not show as master pending
    assign mst_pend = ((st_q == i2cm_pkg::ST_IDLE) || (st_q == i2cm_pkg::ST_PEND))
        && !dma_en_q;

    always_comb begin
        set_w = 32'h0000_0000;
        set_w[`I2CM_B_ARB] = arb_ev_q;
        set_w[`I2CM_B_SSERR] = sserr_ev_q;
        set_w[`I2CM_B_SDESEL] = slv_deselected_i;
        set_w[`I2CM_B_MOV] = mon_overflow_i;
        set_w[`I2CM_B_MIDLE] = mon_idle_i;
        set_w[`I2CM_B_EVTO] = ev_to;
        set_w[`I2CM_B_SCLTO] = scl_to;
    end

    always_comb begin
        raw_w = sticky_q;
        raw_w[`I2CM_B_MPEND] = mst_pend;
        raw_w[`I2CM_B_SPEND] = slv_pend_q;
        raw_w[`I2CM_B_SNSTR] = slv_nstr_q;
        raw_w[`I2CM_B_MRDY] = mon_rdy_q;
    end

    assign clr_w = (wr_i && sel_w == i2cm_pkg::SEL_RAW) ? (wdata_i & `I2CM_STICKY)
        : 32'h0000_0000;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sticky_q <= `I2CM_RAW_RST & `I2CM_STICKY;
        end else begin
            // a set arriving with its clear wins
            sticky_q <= ((sticky_q & ~clr_w) | set_w) & `I2CM_STICKY;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ien_q <= 32'h0000_0000;
        end else if (wr_i && sel_w == i2cm_pkg::SEL_IEN) begin
            ien_q <= wdata_i & `I2CM_IEN_BITS;
        end
    end

    assign irq_o = |(raw_w & ien_q);

    // the masked view has no write decode at all
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (!rd_i) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            case (sel_w)
                i2cm_pkg::SEL_RAW: rdata_q <= raw_w;
                i2cm_pkg::SEL_IEN: rdata_q <= ien_q;
                i2cm_pkg::SEL_MSK: rdata_q <= raw_w & ien_q;
                i2cm_pkg::SEL_CMD: rdata_q <= {28'h0000000, dma_en_q, 3'h0};
                i2cm_pkg::SEL_DAT: rdata_q <= {23'h000000, last_ack_q, rx_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    property p_masked;
        rd_i && sel_w == i2cm_pkg::SEL_MSK |=> rdata_o == ($past(raw_w) & $past(ien_q));
    endproperty
    a_masked: assert property (p_masked) else $error("masked view wrong");

    property p_arb;
        arb_ev_q |-> ##1 raw_w[`I2CM_B_ARB] && st_q == i2cm_pkg::ST_IDLE;
    endproperty
    a_arb: assert property (p_arb) else $error("arbitration loss not flagged");

    property p_desel;
        slv_deselected_i ##1 !(wr_i && sel_w == i2cm_pkg::SEL_RAW) |-> raw_w[`I2CM_B_SDESEL];
    endproperty
    a_desel: assert property (p_desel) else $error("deselect not sticky");

    property p_sclto;
        scl_run && scl_cnt_q == 12'(`I2CM_TOUT_CYC - 1) |=> raw_w[`I2CM_B_SCLTO];
    endproperty
    a_sclto: assert property (p_sclto) else $error("clock time-out not flagged");

    property p_cont;
        st_q == i2cm_pkg::ST_PEND && go_cont && !go_start && !go_stop && !rcv_q
            |=> st_q == i2cm_pkg::ST_BIT && nbit_q == 4'h9 && tx_sh_q[8:1] == $past(tx_now);
    endproperty
    a_cont: assert property (p_cont) else $error("continue did not start byte");

    property p_start;
        st_q == i2cm_pkg::ST_IDLE && go_start |=> st_q == i2cm_pkg::ST_START
            ##1 !sda_oe_o [*3];
    endproperty
    a_start: assert property (p_start) else $error("start not begun");

    property p_stop_nack;
        st_q == i2cm_pkg::ST_PEND && go_stop && rcv_q && ack_due_q
            |=> st_q == i2cm_pkg::ST_BIT && nbit_q == 4'h1 && tx_sh_q[8]
            && then_q == i2cm_pkg::THEN_STOP;
    endproperty
    a_stop_nack: assert property (p_stop_nack) else $error("nack before stop missing");

    property p_dma_req;
        dma_req_o |-> dma_en_q && st_q == i2cm_pkg::ST_PEND && !mst_pend;
    endproperty
    a_dma_req: assert property (p_dma_req) else $error("dma request without enable");

    property p_auto_ack;
        dma_go && rcv_q && ack_due_q |=> !tx_sh_q[8] && nbit_q == 4'h9 && rxb_q;
    endproperty
    a_auto_ack: assert property (p_auto_ack) else $error("dma byte not acknowledged");

    property p_ro;
        wr_i && sel_w == i2cm_pkg::SEL_MSK |=> ien_q == $past(ien_q);
    endproperty
    a_ro: assert property (p_ro) else $error("masked view write had effect");
endmodule
`default_nettype wire

// ### verification/i2cm_slave_model.sv
// i2cm_slave_model: i2c slave that acknowledges every byte written to it and keeps the last one
// assumes resolved idle-high scl and sda lines
`timescale 1ns/10ps
`default_nettype none
module i2cm_slave_model (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_o,
    output logic [7:0] byte_o
);
    // byte returned to a reading master, bit 0 low so a later nack shows
    localparam logic [7:0] rd_byte = 8'hC6;
    logic [3:0] n = 4'hF;
    logic [7:0] sh = 8'h00;
    logic rd = 1'b0;
    logic first = 1'b0;
    initial sda_oe_o = 1'b0;
    initial byte_o = 8'h00;
    always @(negedge sda_i) begin
        if (scl_i) begin
            n = 4'h0;
            first = 1'b1;
            rd = 1'b0;
        end
    end
    always @(posedge sda_i) begin
        if (scl_i) begin
            n = 4'hF;
            rd = 1'b0;
        end
    end
    always @(posedge scl_i) begin
        // a nack from the reading master ends the slave's turn
        if (n == 4'h8 && rd && !first && sda_i) rd = 1'b0;
        if (n < 4'h8) sh = {sh[6:0], sda_i};
        if (n < 4'h9) n = n + 4'h1;
    end
    // data changes only while scl is low; ack held through the ninth bit
    always @(negedge scl_i) begin
        if (n == 4'h8) begin
            byte_o = sh;
            if (first) rd = sh[0];
        end
        if (n == 4'h9) begin
            n = 4'h0;
            first = 1'b0;
        end
        sda_oe_o = (rd && !first) ? (n < 4'h8 && !rd_byte[3'h7 - n[2:0]]) : (n == 4'h8);
    end
endmodule
`default_nettype wire

// ### verification/i2cm_ctrl_tb_top.sv
// i2cm_ctrl_tb_top: self-checking bench of the master command and interrupt block
// assumes the design files and the slave model are compiled first
`include "i2cm_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module i2cm_ctrl_tb_top;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, v;
    logic wr = 1'b0, rd = 1'b0, ack = 1'b0, req, irq, soe, doe, moe;
    logic sp = 1'b0, sns = 1'b1, sd = 1'b0, mr = 1'b0, mo = 1'b0, mi = 1'b0, grab = 1'b0;
    logic [7:0] dwd = 8'h00, rx, drd;
    int n_mismatch = 0, checks = 0;
    wire scl = ~soe;
    // grab: another master holding the data line low
    wire sda = ~(doe | moe | grab);
    always #2.5 clk_i = ~clk_i;
    i2cm_ctrl dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .scl_i(scl), .scl_o(), .scl_oe_o(soe),
        .sda_i(sda), .sda_o(), .sda_oe_o(doe), .slv_pending_i(sp),
        .slv_not_stretching_i(sns), .slv_deselected_i(sd), .mon_ready_i(mr),
        .mon_overflow_i(mo), .mon_idle_i(mi), .dma_req_o(req), .dma_ack_i(ack),
        .dma_wdata_i(dwd), .dma_rdata_o(drd), .irq_o(irq));
    i2cm_slave_model slv (.scl_i(scl), .sda_i(sda), .sda_oe_o(moe), .byte_o(rx));
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", s, e, g);
            n_mismatch++;
        end
    endtask
    task automatic w(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic r(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // poll raw status until master pending, bounded
    task automatic wait_pend();
        for (int i = 0; i < 8000; i++) begin
            r(`I2CM_ADDR_RAW, v);
            if (v[0] === 1'b1) return;
        end
        chk("pending_wait", 32'h1, 32'h0);
        conclude();
    endtask
    // k=1 waits on dma request, k=0 on the data line
    task automatic wt(input bit k, input logic lvl);
        for (int i = 0; i < 8000; i++) begin
            @(negedge clk_i);
            if ((k ? req : sda) === lvl) return;
        end
        chk("line_wait", {31'h0, lvl}, {31'h0, ~lvl});
        conclude();
    endtask
    task automatic t_reset();
        r(`I2CM_ADDR_RAW, v);
        chk("raw", 32'h0000_0801, v);
        r(`I2CM_ADDR_MSK, v);
        chk("msk", 32'h0, v);
        chk("irq", 32'h0, {31'h0, irq});
        $display("end reset");
    endtask
    task automatic t_status();
        w(`I2CM_ADDR_IEN, `I2CM_IEN_BITS);
        r(`I2CM_ADDR_MSK, v);
        chk("msk", 32'h0000_0801, v);
        sp <= 1'b1;
        mr <= 1'b1;
        sd <= 1'b1;
        mo <= 1'b1;
        mi <= 1'b1;
        @(posedge clk_i);
        sd <= 1'b0;
        mo <= 1'b0;
        mi <= 1'b0;
        r(`I2CM_ADDR_MSK, v);
        chk("msk", 32'h000B_8901, v);
        w(`I2CM_ADDR_MSK, 32'hFFFF_FFFF);
        r(`I2CM_ADDR_RAW, v);
        chk("raw", 32'h000B_8901, v);
        w(`I2CM_ADDR_IEN, 32'h0002_0000);
        r(`I2CM_ADDR_MSK, v);
        chk("msk", 32'h0002_0000, v);
        chk("irq", 32'h1, {31'h0, irq});
        w(`I2CM_ADDR_IEN, 32'h0);
        #1 chk("irq", 32'h0, {31'h0, irq});
        w(`I2CM_ADDR_RAW, 32'h000A_8000);
        r(`I2CM_ADDR_RAW, v);
        chk("raw", 32'h0001_0901, v);
        sp <= 1'b0;
        mr <= 1'b0;
        $display("end status");
    endtask
    task automatic t_error();
        w(`I2CM_ADDR_CMD, 32'h0);
        r(`I2CM_ADDR_RAW, v);
        chk("raw", 32'h0000_0801, v);
        w(`I2CM_ADDR_CMD, 32'h4);
        r(`I2CM_ADDR_RAW, v);
        chk("raw", 32'h0000_0841, v);
        w(`I2CM_ADDR_RAW, 32'h40);
        $display("end error");
    endtask
    task automatic t_xfer();
        w(`I2CM_ADDR_DAT, 32'hA4);
        w(`I2CM_ADDR_CMD, 32'h2);
        wt(1'b0, 1'b0);
        chk("scl_at_start", 32'h1, {31'h0, scl});
        wait_pend();
        chk("addr_byte", 32'hA4, {24'h0, rx});
        chk("req", 32'h0, {31'h0, req});
        w(`I2CM_ADDR_CMD, 32'h0);
        repeat (4100) @(posedge clk_i);
        chk("scl_held", 32'h0, {31'h0, scl});
        r(`I2CM_ADDR_RAW, v);
        chk("raw", 32'h0300_0801, v & 32'h0300_0FFF);
        w(`I2CM_ADDR_RAW, 32'h0300_0000);
        w(`I2CM_ADDR_DAT, 32'h5A);
        w(`I2CM_ADDR_CMD, 32'h1);
        wait_pend();
        chk("data_byte", 32'h5A, {24'h0, rx});
        w(`I2CM_ADDR_CMD, 32'h8);
        #1 chk("req", 32'h1, {31'h0, req});
        r(`I2CM_ADDR_RAW, v);
        chk("pend", 32'h0, {31'h0, v[0]});
        @(posedge clk_i);
        ack <= 1'b1;
        dwd <= 8'h3C;
        @(posedge clk_i);
        ack <= 1'b0;
        #1 chk("req", 32'h0, {31'h0, req});
        wt(1'b1, 1'b1);
        chk("dma_byte", 32'h3C, {24'h0, rx});
        w(`I2CM_ADDR_CMD, 32'h4);
        wt(1'b0, 1'b0);
        wt(1'b0, 1'b1);
        chk("scl_at_stop", 32'h1, {31'h0, scl});
        wait_pend();
        $display("end transfer");
    endtask
    task automatic t_arb();
        w(`I2CM_ADDR_DAT, 32'h80);
        w(`I2CM_ADDR_CMD, 32'h2);
        wt(1'b0, 1'b0);
        @(posedge clk_i);
        grab <= 1'b1;
        wait_pend();
        grab <= 1'b0;
        r(`I2CM_ADDR_RAW, v);
        chk("arb", 32'h10, v & 32'h10);
        w(`I2CM_ADDR_RAW, 32'h10);
        $display("end arbitration");
    endtask
    task automatic t_rx();
        w(`I2CM_ADDR_DAT, 32'hA5);
        w(`I2CM_ADDR_CMD, 32'h2);
        wait_pend();
        w(`I2CM_ADDR_CMD, 32'h1);
        wait_pend();
        r(`I2CM_ADDR_DAT, v);
        chk("rx_byte", 32'h0C6, v);
        w(`I2CM_ADDR_CMD, 32'h9);
        wt(1'b1, 1'b1);
        chk("ack_byte", 32'hC6, {24'h0, drd});
        @(posedge clk_i);
        ack <= 1'b1;
        @(posedge clk_i);
        ack <= 1'b0;
        wt(1'b1, 1'b1);
        chk("dma_rx_byte", 32'hC6, {24'h0, drd});
        w(`I2CM_ADDR_CMD, 32'h4);
        wt(1'b0, 1'b0);
        wt(1'b0, 1'b1);
        chk("scl_at_rx_stop", 32'h1, {31'h0, scl});
        r(`I2CM_ADDR_DAT, v);
        chk("nack", 32'h1, {31'h0, v[8]});
        $display("end receive");
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_status();
        t_error();
        t_xfer();
        t_arb();
        t_rx();
        conclude();
    end
endmodule
`default_nettype wire
